// ===== pkg/srp_map.svh
/*
 * Constants of the serial register port: frame layout, control bits
 * of register 0 and link timing. Included by srp_pkg, srp_device and srp_host.
 */
`ifndef SRP_MAP_SVH
`define SRP_MAP_SVH

`define SRP_FRAME_BITS 30
`define SRP_ADDR_BITS 10
`define SRP_DATA_BITS 20
`define SRP_CNT_BITS 5
`define SRP_CNT_MAX 5'h1F
`define SRP_CNT_FRAME 5'h1E
`define SRP_CNT_ADDR 5'h0A
`define SRP_HOST_LAST_BIT 5'h1D
`define SRP_HOST_LAST_ADDR 5'h09
`define SRP_REG_WORDS 16
`define SRP_CTRL_ADDR 10'h000
`define SRP_CTRL_RW_BIT 0
`define SRP_CTRL_BIDIR_BIT 1
`define SRP_CTRL_RBSEL_BIT 2
`define SRP_RESET_WORD 20'h00000
`define SRP_SCLK_PERIOD_NS 64
`define SRP_CLK_PERIOD_NS 4
`define SRP_HALF_CYCLES ((`SRP_SCLK_PERIOD_NS / `SRP_CLK_PERIOD_NS) / 2)
`define SRP_DIV_BITS 4

`endif

// ===== pkg/srp_pkg.sv
/*
 * Types for the two ends of the serial register port; srp_hstate_t serves the controller only.
 * Assumes srp_map.svh on the include path.
 */
`include "srp_map.svh"

package srp_pkg;
   typedef logic [`SRP_ADDR_BITS-1:0] srp_addr_t;
   typedef logic [`SRP_DATA_BITS-1:0] srp_data_t;
   typedef logic [`SRP_FRAME_BITS-1:0] srp_frame_t;
   typedef logic [`SRP_CNT_BITS-1:0] srp_cnt_t;
   typedef enum logic [4:0] {
      SRP_H_IDLE = 5'h01,
      SRP_H_LEAD = 5'h02,
      SRP_H_SHIFT = 5'h04,
      SRP_H_TAIL = 5'h08,
      SRP_H_GAP = 5'h10
   } srp_hstate_t;
endpackage : srp_pkg

// ===== pkg/srp_if.sv
/*
 * Link between controller and device: serial clock, frame select,
 * two-way data line and readback line. Resolves the data line.
 */
`timescale 1ns/1ps
`default_nettype none

interface srp_if;
   logic sclk;
   logic frame_select_n;
   logic host_sdi_out;
   logic host_sdi_oe;
   logic dev_sdi_out;
   logic dev_sdi_oe;
   logic serial_in_io;
   logic serial_readback_out;

   // undriven line reads low: each end's bit is gated by its own enable
   assign serial_in_io = (host_sdi_oe & host_sdi_out) |
                         (dev_sdi_oe & dev_sdi_out);

   modport device (
      input sclk, frame_select_n, serial_in_io,
      output dev_sdi_out, dev_sdi_oe, serial_readback_out
   );
   modport host (
      input serial_in_io, serial_readback_out,
      output sclk, frame_select_n, host_sdi_out, host_sdi_oe
   );
endinterface : srp_if

`default_nettype wire

// ===== rtl/srp_device.sv
/*
 * Device end of the serial register port: shifts frames in, writes
 * the register file, shifts read data out on either data pin.
 * Assumes i_clk far faster than the link clock (at least 6 clocks
 * per half link period); all link pins are asynchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

`include "srp_map.svh"

module srp_device (
   srp_if.device link,                  // link to the controller
   input wire logic i_clk,              // core clock
   input wire logic i_rst_n,            // sync reset, active low
   input wire logic i_gpio_value,       // gpio level for shared pin
   output logic o_cfg_wr,               // one-cycle write strobe
   output srp_pkg::srp_addr_t o_cfg_addr, // address of last write
   output srp_pkg::srp_data_t o_cfg_data, // data of last write
   output logic o_read_mode,            // read access selected
   output logic o_bidir                 // three-wire mode selected
);
   import srp_pkg::*;

   // ************************************************************
   // pin synchronisers and edge detection
   // ************************************************************
   logic [1:0] sclk_sync_reg;
   logic [1:0] sel_sync_reg;
   logic [1:0] sdi_sync_reg;
   logic sclk_d_reg;
   logic sel_d_reg;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_rise;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sclk_sync_reg <= 2'h0;
         sel_sync_reg <= 2'h3;
         sdi_sync_reg <= 2'h0; // released line idles low
         sclk_d_reg <= 1'b0;
         sel_d_reg <= 1'b1;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
         sel_sync_reg <= {sel_sync_reg[0], link.frame_select_n};
         sdi_sync_reg <= {sdi_sync_reg[0], link.serial_in_io};
         sclk_d_reg <= sclk_sync_reg[1];
         sel_d_reg <= sel_sync_reg[1];
      end
   end

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_d_reg;
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_d_reg;
   assign sel_rise = sel_sync_reg[1] & ~sel_d_reg;

   // ************************************************************
   // input shifter and bit count
   // ************************************************************
   srp_frame_t shift_reg;
   srp_cnt_t cnt_reg;
   srp_addr_t frame_addr;
   srp_data_t frame_data;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         shift_reg <= '0;
         cnt_reg <= '0;
      end else if (sel_sync_reg[1]) begin
         cnt_reg <= '0;
      end else if (sclk_rise) begin
         // address enters first, so it ends up in the top bits
         shift_reg <= {shift_reg[`SRP_FRAME_BITS-2:0], sdi_sync_reg[1]};
         // saturate: an overlong frame never matches the full count
         if (cnt_reg != `SRP_CNT_MAX) begin
            cnt_reg <= cnt_reg + 5'h01;
         end
      end
   end

   assign frame_addr = shift_reg[`SRP_FRAME_BITS-1:`SRP_DATA_BITS];
   assign frame_data = shift_reg[`SRP_DATA_BITS-1:0];

   // ************************************************************
   // frame latch and register file
   // ************************************************************
   srp_data_t regs [`SRP_REG_WORDS];
   logic read_mode;
   logic bidir;
   logic rb_sel;
   logic frame_ok;

   assign read_mode = regs[0][`SRP_CTRL_RW_BIT];
   assign bidir = regs[0][`SRP_CTRL_BIDIR_BIT];
   assign rb_sel = regs[0][`SRP_CTRL_RBSEL_BIT];

   // only exactly 30 bits count; in read mode address 0 still
   // writes so the controller can get back to write mode
   assign frame_ok = sel_rise && (cnt_reg == `SRP_CNT_FRAME) &&
                     (!read_mode || frame_addr == `SRP_CTRL_ADDR);

   genvar gi;
   generate
      for (gi = 0; gi < `SRP_REG_WORDS; gi++) begin : g_word
         always_ff @(posedge i_clk) begin
            if (!i_rst_n) begin
               regs[gi] <= `SRP_RESET_WORD; // write mode after reset
            end else if (frame_ok &&
                         frame_addr == srp_addr_t'(gi)) begin
               regs[gi] <= frame_data;
            end
         end
      end
   endgenerate

   // whole frame leaves at select rise toward the rest of the chip
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_cfg_wr <= 1'b0;
         o_cfg_addr <= '0;
         o_cfg_data <= '0;
      end else begin
         o_cfg_wr <= frame_ok;
         if (frame_ok) begin
            o_cfg_addr <= frame_addr;
            o_cfg_data <= frame_data;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_read_mode <= 1'b0;
         o_bidir <= 1'b0;
      end else begin
         o_read_mode <= read_mode;
         o_bidir <= bidir;
      end
   end

   // ************************************************************
   // read data shifter
   // ************************************************************
   srp_data_t out_reg;
   logic drv_reg;
   srp_data_t rd_word;
   srp_addr_t rd_addr;

   assign rd_addr = shift_reg[`SRP_ADDR_BITS-1:0];
   // addresses above the local file read as zero
   assign rd_word = (rd_addr < srp_addr_t'(`SRP_REG_WORDS)) ?
                    regs[rd_addr[3:0]] : '0;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || sel_sync_reg[1]) begin
         out_reg <= '0;
         drv_reg <= 1'b0;
      end else if (sclk_fall && read_mode) begin
         if (cnt_reg == `SRP_CNT_ADDR) begin
            out_reg <= rd_word;
            drv_reg <= 1'b1; // first fall after the last address bit
         end else if (drv_reg) begin
            out_reg <= {out_reg[`SRP_DATA_BITS-2:0], 1'b0};
         end
      end
   end

   // ************************************************************
   // pin drivers, one flop each
   // ************************************************************
   logic sdi_out_reg;
   logic sdi_oe_reg;
   logic rb_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sdi_out_reg <= 1'b0;
         sdi_oe_reg <= 1'b0;
         rb_reg <= 1'b0;
      end else begin
         sdi_out_reg <= out_reg[`SRP_DATA_BITS-1];
         sdi_oe_reg <= drv_reg & bidir & ~sel_sync_reg[1];
         // shared pin: gpio level until readback is chosen
         rb_reg <= rb_sel ? (out_reg[`SRP_DATA_BITS-1] & drv_reg)
                          : i_gpio_value;
      end
   end

   assign link.dev_sdi_out = sdi_out_reg;
   assign link.dev_sdi_oe = sdi_oe_reg;
   assign link.serial_readback_out = rb_reg;

endmodule : srp_device

`default_nettype wire

// ===== rtl/srp_host.sv
/*
 * Controller end of the serial register port: makes the link clock
 * by a divider, sends 30-bit frames, collects read data.
 * Assumes the device end updates its data within 6 clocks of a fall.
 */
`timescale 1ns/1ps
`default_nettype none

`include "srp_map.svh"

module srp_host (
   srp_if.host link,                    // link to the device
   input wire logic i_clk,              // core clock
   input wire logic i_rst_n,            // sync reset, active low
   input wire logic i_start,            // start a frame, taken idle
   input wire logic i_read,             // frame is a read access
   input wire logic i_three_wire,       // read back on the data pin
   input wire srp_pkg::srp_addr_t i_addr,  // register address
   input wire srp_pkg::srp_data_t i_wdata, // write data
   output logic o_busy,                 // frame in progress
   output logic o_done,                 // one-cycle end of frame
   output srp_pkg::srp_data_t o_rdata   // read data of last read frame
);
   import srp_pkg::*;

   // ************************************************************
   // synchronisers for returning data
   // ************************************************************
   logic [1:0] sdi_sync_reg;
   logic [1:0] rb_sync_reg;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sdi_sync_reg <= 2'h0;
         rb_sync_reg <= 2'h0;
      end else begin
         sdi_sync_reg <= {sdi_sync_reg[0], link.serial_in_io};
         rb_sync_reg <= {rb_sync_reg[0], link.serial_readback_out};
      end
   end

   // ************************************************************
   // half-period divider
   // ************************************************************
   srp_hstate_t state_reg;
   logic [`SRP_DIV_BITS-1:0] div_reg;
   logic tick;

   assign tick = (div_reg == `SRP_DIV_BITS'(`SRP_HALF_CYCLES - 1));

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || state_reg == SRP_H_IDLE || tick) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   // ************************************************************
   // frame sequencer
   // ************************************************************
   srp_frame_t frame_reg;
   srp_cnt_t bit_reg;
   logic read_reg;
   logic three_reg;
   logic sclk_reg;
   logic sel_n_reg;
   logic oe_reg;
   logic sample;

   assign sample = three_reg ? sdi_sync_reg[1] : rb_sync_reg[1];

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_reg <= SRP_H_IDLE;
         frame_reg <= '0;
         bit_reg <= '0;
         read_reg <= 1'b0;
         three_reg <= 1'b0;
         sclk_reg <= 1'b0;
         sel_n_reg <= 1'b1;
         oe_reg <= 1'b0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_rdata <= '0;
      end else begin
         o_done <= 1'b0;
         case (state_reg)
            SRP_H_IDLE: begin
               if (i_start) begin
                  frame_reg <= {i_addr, i_wdata}; // address first
                  read_reg <= i_read;
                  three_reg <= i_three_wire;
                  bit_reg <= '0;
                  sel_n_reg <= 1'b0;
                  oe_reg <= 1'b1;
                  o_busy <= 1'b1;
                  state_reg <= SRP_H_LEAD;
               end
            end
            SRP_H_LEAD: begin
               if (tick) begin
                  sclk_reg <= 1'b1;
                  state_reg <= SRP_H_SHIFT;
               end
            end
            SRP_H_SHIFT: begin
               if (tick && sclk_reg) begin
                  sclk_reg <= 1'b0;
                  if (bit_reg == `SRP_HOST_LAST_BIT) begin
                     state_reg <= SRP_H_TAIL;
                  end else begin
                     bit_reg <= bit_reg + 5'h01;
                     frame_reg <= {frame_reg[`SRP_FRAME_BITS-2:0], 1'b0};
                  end
                  // let go of the line as the device takes it
                  if (read_reg && three_reg &&
                      bit_reg == `SRP_HOST_LAST_ADDR) begin
                     oe_reg <= 1'b0;
                  end
               end else if (tick) begin
                  sclk_reg <= 1'b1;
               end
               // sample at the rising edge of each data bit
               if (tick && !sclk_reg && read_reg &&
                   bit_reg >= `SRP_CNT_ADDR) begin
                  o_rdata <= {o_rdata[`SRP_DATA_BITS-2:0], sample};
               end
            end
            SRP_H_TAIL: begin
               if (tick) begin
                  sel_n_reg <= 1'b1; // latches the frame in the device
                  oe_reg <= 1'b0;
                  state_reg <= SRP_H_GAP;
               end
            end
            SRP_H_GAP: begin
               // keeps select high long enough for the device to see it
               if (tick) begin
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
                  state_reg <= SRP_H_IDLE;
               end
            end
            default: begin
               state_reg <= SRP_H_IDLE;
            end
         endcase
      end
   end

   // first rising edge uses bit 29, so sampling on that edge is fixed
   assign link.sclk = sclk_reg;
   assign link.frame_select_n = sel_n_reg;
   assign link.host_sdi_out = frame_reg[`SRP_FRAME_BITS-1];
   assign link.host_sdi_oe = oe_reg;

endmodule : srp_host

`default_nettype wire

// ===== tb/srp_checker.sv
/*
 * Concurrent checks on the link between controller and device.
 * Assumes the link signals of one srp_if and the core clock/reset.
 */
`timescale 1ns/1ps
`default_nettype none

module srp_checker (
   input wire logic i_clk,               // core clock
   input wire logic i_rst_n,             // sync reset, active low
   input wire logic sclk,                // link clock
   input wire logic frame_select_n,      // frame enable
   input wire logic host_sdi_out,        // host data bit
   input wire logic host_sdi_oe,         // host drives data line
   input wire logic dev_sdi_out,         // device data bit
   input wire logic dev_sdi_oe,          // device drives data line
   input wire logic serial_in_io,        // resolved data line
   input wire logic serial_readback_out  // readback pin
);
   logic sclk_reg;
   logic [4:0] bits_reg;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // ****************************************
   // rising link edges seen in a frame
   // ****************************************
   always_ff @(posedge i_clk) begin
      sclk_reg <= sclk;
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || frame_select_n)
         bits_reg <= 5'h00;
      else if (sclk && !sclk_reg)
         bits_reg <= bits_reg + 5'h01;
   end

   // ****************************************
   // link rules
   // ****************************************
   frame_len_a: assert property (
      $rose(frame_select_n) |-> bits_reg == 5'h1E)
      else $error("frame closed without exactly 30 link clocks");
   idle_clock_a: assert property (
      frame_select_n |-> !sclk)
      else $error("link clock moves outside a frame");
   lead_time_a: assert property (
      $fell(frame_select_n) |-> !sclk [*8])
      else $error("link clock rose too soon after select");
   high_half_a: assert property (
      $rose(sclk) |=> sclk [*7])
      else $error("link clock high half too short");
   low_half_a: assert property (
      $fell(sclk) && !frame_select_n |=> !sclk [*7])
      else $error("link clock low half too short");
   select_gap_a: assert property (
      $rose(frame_select_n) |-> frame_select_n [*3])
      else $error("select high gap too short");
   no_clash_a: assert property (
      !(host_sdi_oe && dev_sdi_oe))
      else $error("both ends drive the data line");
   pull_down_a: assert property (
      !host_sdi_oe && !dev_sdi_oe |-> !serial_in_io)
      else $error("released data line not low");
   turn_over_a: assert property (
      $rose(dev_sdi_oe) |-> !sclk && !frame_select_n && !host_sdi_oe)
      else $error("device took the line at a wrong moment");
   host_drive_a: assert property (
      host_sdi_oe |-> !frame_select_n)
      else $error("host drives data outside a frame");
   host_hold_a: assert property (
      sclk && $past(sclk) && host_sdi_oe |-> $stable(host_sdi_out))
      else $error("host data moved while link clock high");
   dev_hold_a: assert property (
      sclk && $past(sclk) && dev_sdi_oe |-> $stable(dev_sdi_out))
      else $error("device data moved while link clock high");
   rb_hold_a: assert property (
      sclk && $past(sclk) |-> $stable(serial_readback_out))
      else $error("readback moved while link clock high");
endmodule : srp_checker

`default_nettype wire

// ===== tb/serial_register_port_test.sv
/*
 * Self-checking bench: host and device joined by srp_if, plus a second
 * device fed by a bench driver that sends wrong-length frames.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_register_port_test;
   import srp_pkg::*;
   logic i_clk, i_rst_n, i_start, i_read, i_three_wire, i_gpio_value;
   srp_addr_t i_addr, o_cfg_addr, b_addr;
   srp_data_t i_wdata, o_rdata, o_cfg_data, b_data;
   logic o_busy, o_done, o_cfg_wr, o_read_mode, o_bidir, b_wr;
   int n_fail, checks;
   logic [31:0] rnd;
   srp_frame_t wq[$];
   logic [20:0] rq[$];
   srp_data_t mem[16];
   logic [31:0] note;

   srp_if link();
   srp_if link_b();

   srp_host u_srp_host (.link(link), .i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_start(i_start), .i_read(i_read), .i_three_wire(i_three_wire),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_busy(o_busy),
      .o_done(o_done), .o_rdata(o_rdata));
   srp_device u_srp_device (.link(link), .i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_gpio_value(i_gpio_value), .o_cfg_wr(o_cfg_wr),
      .o_cfg_addr(o_cfg_addr), .o_cfg_data(o_cfg_data),
      .o_read_mode(o_read_mode), .o_bidir(o_bidir));
   srp_device u_srp_device_b (.link(link_b), .i_clk(i_clk),
      .i_rst_n(i_rst_n), .i_gpio_value(i_gpio_value), .o_cfg_wr(b_wr),
      .o_cfg_addr(b_addr), .o_cfg_data(b_data), .o_read_mode(),
      .o_bidir());
   srp_checker u_srp_checker (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .sclk(link.sclk), .frame_select_n(link.frame_select_n),
      .host_sdi_out(link.host_sdi_out), .host_sdi_oe(link.host_sdi_oe),
      .dev_sdi_out(link.dev_sdi_out), .dev_sdi_oe(link.dev_sdi_oe),
      .serial_in_io(link.serial_in_io),
      .serial_readback_out(link.serial_readback_out));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // ****************************************
   // host frames and expectation notes
   // ****************************************
   task automatic frame(input logic rd, input logic tw, input srp_addr_t a,
                        input srp_data_t d);
      int n;
      @(posedge i_clk);
      #1;
      i_start = 1'b1;
      i_read = rd;
      i_three_wire = tw;
      i_addr = a;
      i_wdata = d;
      @(posedge i_clk);
      #1;
      i_start = 1'b0;
      chk(o_busy, 1'b1);
      n = 0;
      while (o_done !== 1'b1 && n < 600) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk({o_busy, o_done}, 2'h1);
      if (n >= 600)
         chk(n, 505);
   endtask : frame

   task automatic wr(input srp_addr_t a, input srp_data_t d);
      if (!mem[0][0] || a == 10'h000) begin
         wq.push_back({a, d});
         if (a < 10'h010)
            mem[a[3:0]] = d;
      end
      rq.push_back(21'h000000);
      frame(1'b0, 1'b0, a, d);
   endtask : wr

   task automatic rd(input srp_addr_t a, input logic tw);
      srp_data_t e;
      e = (a < 10'h010) ? mem[a[3:0]] : 20'h00000;
      if (a == 10'h000)
         wq.push_back({a, e});
      rq.push_back({1'b1, e});
      rnd = xs(rnd);
      frame(1'b1, tw, a, rnd[19:0]);
   endtask : rd

   task automatic do_reset;
      @(posedge i_clk);
      #1;
      i_rst_n = 1'b0;
      repeat (6) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      foreach (mem[i])
         mem[i] = 20'h00000;
   endtask : do_reset

   // fault driver for the second device, 64 ns link clock
   task automatic drive_b(input int nb, input srp_frame_t f);
      @(posedge i_clk);
      #1;
      link_b.frame_select_n = 1'b0;
      link_b.host_sdi_oe = 1'b1;
      for (int i = 0; i < nb; i++) begin
         link_b.host_sdi_out = f[29 - (i % 30)];
         repeat (8) @(posedge i_clk);
         #1;
         link_b.sclk = 1'b1;
         repeat (8) @(posedge i_clk);
         #1;
         link_b.sclk = 1'b0;
      end
      repeat (8) @(posedge i_clk);
      #1;
      link_b.frame_select_n = 1'b1;
      link_b.host_sdi_oe = 1'b0;
      repeat (50) @(posedge i_clk);
   endtask : drive_b

   // ****************************************
   // result monitor
   // ****************************************
   always @(posedge i_clk) begin
      if (o_cfg_wr === 1'b1 || b_wr === 1'b1) begin
         note = (wq.size() > 0) ? 32'(wq.pop_front()) : 32'hFFFFFFFF;
         if (o_cfg_wr === 1'b1)
            chk({o_cfg_addr, o_cfg_data}, note);
         else
            chk({b_addr, b_data}, note);
      end
      if (o_done === 1'b1) begin
         note = (rq.size() > 0) ? 32'(rq.pop_front()) : 32'hFFFFFFFF;
         if (note[20])
            chk(o_rdata, note[19:0]);
      end
   end

   initial begin
      repeat (30000) @(posedge i_clk);
      n_fail++;
      test_done();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {i_start, i_read, i_three_wire, i_gpio_value} = 4'h0;
      i_addr = 10'h000;
      i_wdata = 20'h00000;
      n_fail = 0;
      checks = 0;
      rnd = 32'h6260;
      link_b.sclk = 1'b0;
      link_b.frame_select_n = 1'b1;
      link_b.host_sdi_oe = 1'b0;
      link_b.host_sdi_out = 1'b0;
      i_rst_n = 1'b0;
      do_reset();
      chk({o_read_mode, o_bidir}, 2'h0);
      // odd count leaves gpio high, so the late check can trip
      for (int i = 0; i < 3; i++) begin
         @(posedge i_clk);
         #1;
         i_gpio_value = ~i_gpio_value;
         repeat (3) @(posedge i_clk);
         #1;
         chk(link.serial_readback_out, i_gpio_value);
      end
      for (int i = 1; i < 8; i++) begin
         rnd = xs(rnd);
         wr(10'(i * 2), rnd[19:0]);
      end
      wr(10'h3FF, 20'hA5A5A);
      $display("test write done");
      wr(10'h000, 20'h00005);
      chk({o_read_mode, o_bidir}, 2'h2);
      foreach (mem[i])
         if (i > 0)
            rd(10'(i), 1'b0);
      wr(10'h004, 20'h12345);
      rd(10'h004, 1'b0);
      rd(10'h200, 1'b0);
      wr(10'h000, 20'h00003);
      chk({o_read_mode, o_bidir}, 2'h3);
      rd(10'h00E, 1'b1);
      rd(10'h000, 1'b1);
      rd(10'h00C, 1'b1);
      chk(link.serial_readback_out, i_gpio_value);
      $display("test read done");
      do_reset();
      chk({o_read_mode, o_bidir}, 2'h0);
      rnd = xs(rnd);
      drive_b(29, {10'h003, rnd[19:0]});
      drive_b(31, {10'h003, rnd[19:0]});
      wq.push_back({10'h006, rnd[19:0]});
      drive_b(30, {10'h006, rnd[19:0]});
      chk(wq.size(), 0);
      $display("test frame length done");
      test_done();
   end
endmodule : serial_register_port_test

`default_nettype wire
